// ### rtl/scg_top.sv
/*
  System clock generator: internal oscillator control, prescaler,
  glitch-free CPU source switch, STOP handling, stabilization counter.
  Assumes crystal and external clock edges arrive as one-cycle pulses
  synchronous to sys_clk, option-byte levels static after reset.
*/
`timescale 1ns/1ps
module scg_top (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // register bus
  input  wire scg_pkg::scg_axi_req_s axi_req,
  output      scg_pkg::scg_axi_rsp_s axi_rsp,
  // oscillator edges and STOP wake-up
  input  wire logic                  xtal_tick,
  input  wire logic                  ext_tick,
  input  wire logic                  stop_wake,
  // option byte
  input  wire logic                  opt_ls_stoppable,
  input  wire logic                  opt_wdt_enable,
  input  wire logic                  poweron_clear_mode_opt,
  // clock enables and oscillator runs
  output      scg_pkg::scg_clk_out_s clk_out
);
  import scg_pkg::*;

  typedef struct packed {
    scg_mode_e     mode;
    logic [9:0]    hs_cnt;
    logic [9:0]    ls_cnt;
    logic [3:0]    presc;
    logic [16:0]   stab_cnt;
    logic [4:0]    stab_st;
    logic [1:0]    osc_mode;
    logic [2:0]    stab_sel;
    logic          xtal_stop;
    logic          ext_sel;
    logic          cpu_req;
    logic          cpu_act;
    logic [2:0]    pcc;
    logic          aw_got;
    logic          w_got;
    logic [31:0]   awaddr;
    logic [7:0]    wdata;
    logic          wstrb0;
    scg_axi_rsp_s  rsp;
    scg_clk_out_s  out;
  } scg_state_s;

  scg_state_s s;
  scg_state_s n;

  logic       hs_run;
  logic       ls_run;
  logic       hsys_run;
  logic       hs_tick;
  logic       ls_tick;
  logic       hsys_tick;
  logic       main_tick;
  logic [4:0] div_en;
  logic [2:0] pcc_eff;
  logic       restart;
  logic       tgt_run;
  logic [3:0] mask;
  logic [31:0] rd;

  assign axi_rsp = s.rsp;
  assign clk_out = s.out;

  always_comb begin
    n = s;
    mask = 4'h0;
    rd = 32'h0000_0000;
    restart = 1'b0;
    hs_run = (s.mode != ST_STOP) && !s.osc_mode[OSC_HS_STOP];
    ls_run = !(opt_ls_stoppable && s.osc_mode[OSC_LS_STOP]);
    hsys_run = (s.mode != ST_STOP) && !s.xtal_stop;
    hs_tick = hs_run && (s.hs_cnt == 10'(HS_DIV - 1));
    ls_tick = ls_run && (s.ls_cnt == 10'(LS_DIV - 1));
    n.hs_cnt = (!hs_run || hs_tick) ? 10'h000 : s.hs_cnt + 10'h001;
    n.ls_cnt = (!ls_run || ls_tick) ? 10'h000 : s.ls_cnt + 10'h001;
    hsys_tick = hsys_run && (s.ext_sel ? ext_tick : xtal_tick);
    // main clock is internal or high-speed system, never low-speed
    main_tick = s.cpu_act ? hsys_tick : hs_tick;
    for (int k = 0; k < 5; k++) begin
      mask = 4'((5'h01 << k) - 5'h01);
      div_en[k] = main_tick && ((s.presc & mask) == mask);
    end
    n.presc = main_tick ? s.presc + 4'h1 : s.presc;
    pcc_eff = (s.pcc > 3'h4) ? 3'h4 : s.pcc;
    // switch only at the end of a full prescaler period, to a live source
    tgt_run = s.cpu_req ? hsys_run : hs_run;
    if (s.cpu_req != s.cpu_act && main_tick && (&s.presc) && tgt_run) begin
      n.cpu_act = s.cpu_req;
      n.presc = 4'h0;
    end

    // STOP release
    unique case (s.mode)
      ST_RUN: ;
      ST_STOP:
        if (stop_wake) begin
          restart = 1'b1;
          // crystal holds CPU; internal or external clock resumes at once
          n.mode = (s.cpu_act && !s.ext_sel) ? ST_WAIT : ST_RUN;
        end
      ST_WAIT:
        if (s.stab_cnt >= stab_thr(s.stab_sel)) begin
          n.mode = ST_RUN;
        end
    endcase

    // AXI write
    if (axi_req.awvalid && s.rsp.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      n.w_got = 1'b1;
      n.wdata = axi_req.wdata[7:0];
      n.wstrb0 = axi_req.wstrb[0];
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = RESP_OKAY;
      unique case (s.awaddr)
        ADDR_OSC_MODE:
          if (s.wstrb0) begin
            // the oscillator feeding the CPU cannot be stopped
            n.osc_mode[OSC_HS_STOP] = s.wdata[OSC_HS_STOP]
              && s.cpu_act && s.cpu_req;
            n.osc_mode[OSC_LS_STOP] = s.wdata[OSC_LS_STOP];
          end
        ADDR_STAB_SEL:
          if (s.wstrb0) begin
            n.stab_sel = s.wdata[2:0];
          end
        ADDR_CLK_CTRL:
          if (s.wstrb0) begin
            n.xtal_stop = s.wdata[CC_XTAL_STOP]
              && !s.cpu_act && !s.cpu_req;
            // pin mode may change only while the crystal is off
            if (s.xtal_stop) begin
              n.ext_sel = s.wdata[CC_EXT_SEL];
            end
            n.cpu_req = s.wdata[CC_CPU_SRC];
            n.pcc = s.wdata[CC_PCC_LSB +: 3];
          end
        ADDR_STOP_CMD:
          if (s.wstrb0 && s.wdata[0] && s.mode == ST_RUN) begin
            n.mode = ST_STOP;
          end
        ADDR_STAB_ST, ADDR_STATUS: ;
        default: n.rsp.bresp = RESP_SLVERR;
      endcase
    end
    n.rsp.awready = !n.aw_got && !n.rsp.bvalid;
    n.rsp.wready = !n.w_got && !n.rsp.bvalid;

    // AXI read
    if (s.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = RESP_OKAY;
      unique case (axi_req.araddr)
        ADDR_OSC_MODE: rd[1:0] = s.osc_mode;
        ADDR_STAB_ST:  rd[4:0] = s.stab_st;
        ADDR_STAB_SEL: rd[2:0] = s.stab_sel;
        ADDR_CLK_CTRL:
          rd[6:0] = {s.pcc, 1'b0, s.cpu_req, s.ext_sel, s.xtal_stop};
        ADDR_STATUS:
          rd[3:0] = {poweron_clear_mode_opt, s.mode == ST_WAIT,
                     s.mode == ST_STOP, s.cpu_act};
        ADDR_STOP_CMD: ;
        default: n.rsp.rresp = RESP_SLVERR;
      endcase
      n.rsp.rdata = rd;
    end
    n.rsp.arready = !n.rsp.rvalid;

    // stabilization counter restarts when crystal starts or STOP ends
    if (s.xtal_stop && !n.xtal_stop) begin
      restart = 1'b1;
    end
    if (restart) begin
      n.stab_cnt = 17'h00000;
      n.stab_st = 5'h00;
    end else if (!s.ext_sel && hsys_run && xtal_tick
                 && s.stab_cnt < stab_thr(s.stab_sel)) begin
      // saturates at the selected time, so status stops there too
      n.stab_cnt = s.stab_cnt + 17'h00001;
    end
    for (int j = 1; j < 6; j++) begin
      if (!restart && n.stab_cnt >= stab_thr(3'(j))) begin
        n.stab_st[5 - j] = 1'b1;
      end
    end

    n.out.cpu_clk_en = (s.mode == ST_RUN) && div_en[pcc_eff];
    n.out.periph_en = div_en;
    n.out.wdt_clk_en = ls_tick && opt_wdt_enable;
    n.out.tmr8_clk_en = ls_tick;
    n.out.hs_run = hs_run;
    n.out.xtal_run = hsys_run && !s.ext_sel;
    n.out.ls_run = ls_run;
    n.out.stop_mode = (s.mode == ST_STOP);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
      s.stab_sel <= STAB_SEL_RST;
      s.xtal_stop <= XTAL_STOP_RST;
      s.pcc <= PCC_RST;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_hs_after_rst: assert property ($fell(reset) |-> ##1 clk_out.hs_run)
    else $error("hs oscillator not running after reset");
  a_hs_stop_ctl: assert property (s.osc_mode[OSC_HS_STOP]
    |=> !clk_out.hs_run)
    else $error("hs oscillator ran while stopped");
  a_ls_tmr_only: assert property (clk_out.wdt_clk_en
    |-> clk_out.tmr8_clk_en ##1 !clk_out.tmr8_clk_en [*8])
    else $error("low-speed enable malformed");
  a_ls_fixed: assert property (!opt_ls_stoppable |=> clk_out.ls_run)
    else $error("fixed low-speed oscillator stopped");
  a_wdt_gate: assert property (!opt_wdt_enable |=> !clk_out.wdt_clk_en)
    else $error("watchdog clocked while disabled");
  a_presc_nest: assert property (clk_out.periph_en[2]
    |-> clk_out.periph_en[1] && clk_out.periph_en[0])
    else $error("prescaler outputs not nested");
  a_cpu_on_hs: assert property ($fell(reset) |-> !s.cpu_act)
    else $error("cpu not on internal clock after reset");
  a_wait_holds: assert property (s.mode == ST_WAIT
    |=> !clk_out.cpu_clk_en)
    else $error("cpu clocked during stabilization wait");
  a_ext_no_wait: assert property (s.mode == ST_STOP && stop_wake
    && s.ext_sel |=> s.mode == ST_RUN)
    else $error("external clock waited after stop");
  a_keep_cpu_src: assert property (!s.cpu_act && !s.cpu_req
    && !s.osc_mode[OSC_HS_STOP] |=> !s.osc_mode[OSC_HS_STOP])
    else $error("cpu source was stopped");
  a_stop_halts: assert property (s.mode == ST_STOP
    |=> !clk_out.hs_run && !clk_out.xtal_run)
    else $error("clocks ran during stop");
  a_sel_reset: assert property ($fell(reset)
    |-> s.stab_sel == STAB_SEL_RST)
    else $error("stabilization select reset wrong");
  a_stab_order: assert property ($rose(s.stab_st[3])
    |-> s.stab_st[4])
    else $error("stabilization status out of order");
  a_glitch_free: assert property ($changed(s.cpu_act)
    |-> s.presc == 4'h0 && $past(s.presc) == 4'hF)
    else $error("cpu source switched mid-period");

endmodule

// ### rtl/scg_pkg.sv
/*
  Constants, types and helpers for the system clock generator.
  Assumes one 200 MHz system clock and an AXI4-Lite register port.
*/
package scg_pkg;

  // rates in kHz; dividers round down to whole cycles
  localparam int SYS_FREQ_KHZ = 200000;
  localparam int HS_FREQ_KHZ  = 16000;
  localparam int LS_FREQ_KHZ  = 240;
  localparam int HS_DIV       = SYS_FREQ_KHZ / HS_FREQ_KHZ;
  localparam int LS_DIV       = SYS_FREQ_KHZ / LS_FREQ_KHZ;

  // register byte addresses
  localparam logic [31:0] ADDR_OSC_MODE = 32'h0000_0000;
  localparam logic [31:0] ADDR_STAB_ST  = 32'h0000_0004;
  localparam logic [31:0] ADDR_STAB_SEL = 32'h0000_0008;
  localparam logic [31:0] ADDR_CLK_CTRL = 32'h0000_000C;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0010;
  localparam logic [31:0] ADDR_STOP_CMD = 32'h0000_0014;

  // field positions
  localparam int OSC_HS_STOP  = 0;
  localparam int OSC_LS_STOP  = 1;
  localparam int CC_XTAL_STOP = 0;
  localparam int CC_EXT_SEL   = 1;
  localparam int CC_CPU_SRC   = 2;
  localparam int CC_PCC_LSB   = 4;

  // reset values
  localparam logic [2:0] STAB_SEL_RST = 3'h5;
  localparam logic [2:0] PCC_RST      = 3'h1;
  localparam logic       XTAL_STOP_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // stabilization thresholds in crystal cycles
  localparam logic [16:0] STAB_T11 = 17'h00800;
  localparam logic [16:0] STAB_T13 = 17'h02000;
  localparam logic [16:0] STAB_T14 = 17'h04000;
  localparam logic [16:0] STAB_T15 = 17'h08000;
  localparam logic [16:0] STAB_T16 = 17'h10000;

  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAIT} scg_mode_e;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } scg_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scg_axi_rsp_s;

  typedef struct packed {
    logic       cpu_clk_en;
    logic [4:0] periph_en;
    logic       wdt_clk_en;
    logic       tmr8_clk_en;
    logic       hs_run;
    logic       xtal_run;
    logic       ls_run;
    logic       stop_mode;
  } scg_clk_out_s;

  // prohibited codes behave as the longest wait
  function automatic logic [16:0] stab_thr(input logic [2:0] sel);
    case (sel)
      3'h1:    stab_thr = STAB_T11;
      3'h2:    stab_thr = STAB_T13;
      3'h3:    stab_thr = STAB_T14;
      3'h4:    stab_thr = STAB_T15;
      default: stab_thr = STAB_T16;
    endcase
  endfunction

endpackage

// ### tb/test_system_clock_generator.sv
/*
  Self-checking bench for the system clock generator top.
  Assumes the bench drives every input; crystal ticks each cycle once t_xtal sets xtal_on.
*/
`timescale 1ns/1ps
module test_system_clock_generator;
  import scg_pkg::*;
  logic         sys_clk   = 1'b0;
  logic         reset     = 1'b1;
  scg_axi_req_s req       = '0;
  scg_axi_rsp_s rsp;
  logic         xtal_tick = 1'b0;
  logic         stop_wake = 1'b0;
  logic         opt_ls    = 1'b0;
  logic         xtal_on   = 1'b0;
  scg_clk_out_s co;
  int           err_total = 0;
  int           checked   = 0;

  always #2.5 sys_clk = ~sys_clk;
  // a tick every cycle keeps the long waits short
  always @(posedge sys_clk) xtal_tick <= xtal_on;

  scg_top scg_top_inst (
    .sys_clk(sys_clk), .reset(reset), .axi_req(req), .axi_rsp(rsp),
    .xtal_tick(xtal_tick), .ext_tick(1'b0), .stop_wake(stop_wake),
    .opt_ls_stoppable(opt_ls), .opt_wdt_enable(1'b1),
    .poweron_clear_mode_opt(1'b1), .clk_out(co));

  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic do_reset;
    reset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic done;
    done = 1'b0;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) done = 1'b1;
    end
    chk("bresp", rsp.bresp, RESP_OKAY);
    req.bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        done = 1'b1;
        d = rsp.rdata;
        r = rsp.rresp;
      end
    end
    req.rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, d, e);
    chk("rresp", r, RESP_OKAY);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk("hs_run", co.hs_run, 1'b1);
    chk("ls_run", co.ls_run, 1'b1);
    chk("xtal_run", co.xtal_run, 1'b0);
    rchk("osc_mode", ADDR_OSC_MODE, 32'h0);
    rchk("stab_sel", ADDR_STAB_SEL, 32'h5);
    rchk("clk_ctrl", ADDR_CLK_CTRL, 32'h11);
    rchk("status", ADDR_STATUS, 32'h8);
    rchk("stab_st", ADDR_STAB_ST, 32'h0);
    rd(ADDR_STATUS, d, r);
    chk("poc_opt", d[3], 1'b1);
    rd(32'h20, d, r);
    chk("unmapped", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
  endtask

  task automatic t_rates;
    int cpu, p0, p4, tm, wd;
    cpu = 0; p0 = 0; p4 = 0; tm = 0; wd = 0;
    for (int i = 0; i < 3 * LS_DIV; i++) begin
      @(posedge sys_clk);
      if (i < 32 * HS_DIV) begin
        cpu += co.cpu_clk_en;
        p0 += co.periph_en[0];
        p4 += co.periph_en[4];
      end
      tm += co.tmr8_clk_en;
      wd += co.wdt_clk_en;
    end
    chk("cpu_en", cpu, 16);
    chk("periph0", p0, 32);
    chk("periph4", p4, 2);
    chk("tmr8", tm, 3);
    chk("wdt", wd, 3);
  endtask

  task automatic t_ls;
    int tm;
    tm = 0;
    wr(ADDR_OSC_MODE, 32'h3);
    chk("ls_fixed", co.ls_run, 1'b1);
    chk("hs_in_use", co.hs_run, 1'b1);
    opt_ls <= 1'b1;
    do_reset;
    wr(ADDR_OSC_MODE, 32'h2);
    chk("ls_stop", co.ls_run, 1'b0);
    repeat (2 * LS_DIV) begin
      @(posedge sys_clk);
      tm += co.tmr8_clk_en;
    end
    chk("tmr8_off", tm, 0);
    wr(ADDR_OSC_MODE, 32'h0);
    chk("ls_again", co.ls_run, 1'b1);
  endtask

  task automatic t_xtal;
    xtal_on <= 1'b1;
    wr(ADDR_CLK_CTRL, 32'h10);
    chk("xtal_on", co.xtal_run, 1'b1);
    repeat (2100) @(posedge sys_clk);
    rchk("stab_a", ADDR_STAB_ST, 32'h10);
    repeat (6200) @(posedge sys_clk);
    rchk("stab_b", ADDR_STAB_ST, 32'h18);
    wr(ADDR_CLK_CTRL, 32'h14);
    repeat (400) @(posedge sys_clk);
    rchk("on_xtal", ADDR_STATUS, 32'h9);
    wr(ADDR_CLK_CTRL, 32'h15);
    chk("xtal_kept", co.xtal_run, 1'b1);
    wr(ADDR_OSC_MODE, 32'h1);
    chk("hs_stop", co.hs_run, 1'b0);
    wr(ADDR_OSC_MODE, 32'h0);
    chk("hs_start", co.hs_run, 1'b1);
  endtask

  task automatic t_stop;
    logic [31:0] d;
    logic [1:0]  r;
    wr(ADDR_STAB_SEL, 32'h1);
    wr(ADDR_STOP_CMD, 32'h1);
    chk("stop", co.stop_mode, 1'b1);
    chk("hs_halt", co.hs_run, 1'b0);
    chk("xtal_halt", co.xtal_run, 1'b0);
    stop_wake <= 1'b1;
    @(posedge sys_clk);
    stop_wake <= 1'b0;
    repeat (1000) @(posedge sys_clk);
    rd(ADDR_STATUS, d, r);
    chk("waiting", d[2], 1'b1);
    repeat (1300) @(posedge sys_clk);
    rd(ADDR_STATUS, d, r);
    chk("resumed", d[2:0], 3'h1);
    chk("stop_end", co.stop_mode, 1'b0);
  endtask

  initial begin
    do_reset;
    t_reset;
    t_rates;
    t_ls;
    t_xtal;
    t_stop;
    give_verdict;
  end

  // the run needs about 15k cycles; limit at 60k
  initial begin
    #(300_000);
    err_total++;
    give_verdict;
  end
endmodule
